/* hdl/readout_pkg.sv */
// What this block does
// - mode 1 clears gate dark charge on every accepted line, up to half the maximum rate
// - clearing mode flushes gate charge after trigger, then acquires the line
// - clearing mode accepts at most half the immediate-readout maximum line rate
// - clearing mode delays exposure start one readout period, duration unchanged
// - one model constant serves as exposure delay and auto exposure ceiling
// - mode 0 picks clearing or immediate readout from measured line rate
// - auto mode clears below about 38 percent of maximum rate, immediate above about 45 percent
// - fast jump across both thresholds may spoil only the first line after
// - rate rise under 10 percent switches mode without spoiling any line
// - auto mode above half maximum rate caps exposure at the model ceiling
// - mode 2 reads out immediately without clearing; it is the reset default
// - clearing at 45 percent internal rate, exposure mode 2 or 7: warning 09
// - in that conflict every other line trigger is skipped
// - readout mode belongs to the saved and restored settings set
// - readout mode readable in full report and in its own query
// - immediate readout starts on falling edge of the external line trigger
// - mode selectable only in low sensitivity and tall pixel; the block has no pixel setting and forces immediate only in high sensitivity
package readout_pkg;
   localparam int          CLK_MHZ        = 250;
   localparam real         EXP_DELAY_US   = 27.5;
   localparam int          EXP_DELAY_CYC  = int'(EXP_DELAY_US * CLK_MHZ);
   localparam real         MAX_RATE_KHZ   = 36.0;
   // minimum line period in immediate readout, cycles
   localparam int          MIN_PERIOD_CYC = int'(1000.0 * CLK_MHZ / MAX_RATE_KHZ);
   localparam int          CLR_PERIOD_CYC = 2 * MIN_PERIOD_CYC;
   localparam real         TO_IMM_KHZ     = 16.4;
   localparam real         TO_CLR_KHZ     = 13.6;
   localparam int          TO_IMM_CYC     = int'(1000.0 * CLK_MHZ / TO_IMM_KHZ);
   localparam int          TO_CLR_CYC     = int'(1000.0 * CLK_MHZ / TO_CLR_KHZ);

   localparam logic [1:0]  MODE_AUTO      = 2'h0;
   localparam logic [1:0]  MODE_CLEAR     = 2'h1;
   localparam logic [1:0]  MODE_IMM       = 2'h2;
   localparam logic [1:0]  MODE_RST       = MODE_IMM;
   localparam logic [1:0]  SENS_LOW       = 2'h0;
   localparam logic [1:0]  SENS_HIGH      = 2'h1;
   localparam logic [3:0]  EXPMODE_RST    = 4'h7;
   localparam logic [7:0]  WARN_CODE      = 8'h09;

   localparam logic [4:0]  ADR_CTRL       = 5'h00;
   localparam logic [4:0]  ADR_EXPOSURE   = 5'h04;
   localparam logic [4:0]  ADR_STATUS     = 5'h08;
   localparam logic [4:0]  ADR_IRQ_STAT   = 5'h0c;
   localparam logic [4:0]  ADR_IRQ_MASK   = 5'h10;
   localparam logic [4:0]  ADR_MODE_Q     = 5'h14;

   localparam int          CTRL_MODE_LSB  = 0;
   localparam int          CTRL_SENS_LSB  = 4;
   localparam int          CTRL_EXPM_LSB  = 8;
   localparam int          CTRL_INT_BIT   = 12;
   localparam int          CTRL_AT45_BIT  = 13;

   localparam int          IRQ_WARN_BIT   = 0;
   localparam int          IRQ_BADVAL_BIT = 1;
   localparam int          IRQ_SKIP_BIT   = 2;
   localparam int          IRQ_SWITCH_BIT = 3;
   localparam int          IRQ_W          = 4;
   localparam logic [31:0] EXPOSURE_RST   = 32'h0000_0fa0;

   typedef enum logic [1:0] {ST_IDLE, ST_CLEAR, ST_DELAY, ST_EXPOSE} line_st_t;
endpackage : readout_pkg

/* hdl/readout_mode_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
module readout_mode_ctrl #(
   parameter int EXP_DELAY_CYCLES = readout_pkg::EXP_DELAY_CYC,
   parameter int CLR_PERIOD_CYCLES = readout_pkg::CLR_PERIOD_CYC,
   parameter int TO_IMM_CYCLES    = readout_pkg::TO_IMM_CYC,
   parameter int TO_CLR_CYCLES    = readout_pkg::TO_CLR_CYC,
   parameter int CNT_W            = 32
) (
   input  wire logic        SYS_CLK,
   input  wire logic        SYS_RST,
   input  wire logic        CLK_EN,
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [4:0]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic      [31:0] WB_DAT_O,
   output logic             WB_ACK_O,
   input  wire logic        EXTERNAL_LINE_TRIGGER,
   input  wire logic        INTERNAL_LINE_PULSE,
   input  wire logic        SETTINGS_RESTORE,
   input  wire logic [1:0]  SETTINGS_MODE_IN,
   output logic      [1:0]  SETTINGS_MODE_OUT,
   output logic             GATE_CLEAR,
   output logic             READOUT_START,
   output logic             EXPOSE,
   output logic             WARN_ACTIVE,
   output logic      [7:0]  WARN_CODE_OUT,
   output logic             IRQ
);
   typedef struct packed {
      logic [1:0]              mode;
      logic [1:0]              sens;
      logic [3:0]              expmode;
      logic                    int_rate;
      logic                    at45;
      logic [31:0]             exposure;
      logic [readout_pkg::IRQ_W-1:0] istat;
      logic [readout_pkg::IRQ_W-1:0] imask;
      logic                    trig_d;
      logic                    skip_tog;
      logic                    eff_clear;
      logic [CNT_W-1:0]        period;
      logic [CNT_W-1:0]        last_period;
      logic [CNT_W-1:0]        cnt;
      readout_pkg::line_st_t   st;
      logic                    ack;
      logic [31:0]             rdat;
      logic                    gclr;
      logic                    rstart;
      logic                    expo;
   } state_t;

   state_t s_reg;
   state_t s_next;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction : merge

   logic        trig_fall;
   logic        line_evt;
   logic        conflict;
   logic        mode_allowed;
   logic [1:0]  eff_mode;
   logic        auto_hi;
   logic [31:0] exp_used;
   logic [31:0] ctrl_word;
   logic [1:0]  req_mode;
   logic [31:0] wv;

   always_comb begin
      trig_fall    = s_reg.trig_d & ~EXTERNAL_LINE_TRIGGER;
      line_evt     = s_reg.int_rate ? INTERNAL_LINE_PULSE : trig_fall;
      mode_allowed = (s_reg.sens != readout_pkg::SENS_HIGH);
      eff_mode     = mode_allowed ? s_reg.mode : readout_pkg::MODE_IMM;
      conflict     = (eff_mode == readout_pkg::MODE_CLEAR) && s_reg.at45
                     && (s_reg.expmode == 4'h2 || s_reg.expmode == 4'h7);
      auto_hi      = (eff_mode == readout_pkg::MODE_AUTO)
                     && (s_reg.last_period < CNT_W'(CLR_PERIOD_CYCLES));
      exp_used     = (auto_hi && s_reg.exposure > 32'(EXP_DELAY_CYCLES))
                     ? 32'(EXP_DELAY_CYCLES) : s_reg.exposure;
      ctrl_word    = '0;
      ctrl_word[readout_pkg::CTRL_MODE_LSB +: 2] = s_reg.mode;
      ctrl_word[readout_pkg::CTRL_SENS_LSB +: 2] = s_reg.sens;
      ctrl_word[readout_pkg::CTRL_EXPM_LSB +: 4] = s_reg.expmode;
      ctrl_word[readout_pkg::CTRL_INT_BIT]       = s_reg.int_rate;
      ctrl_word[readout_pkg::CTRL_AT45_BIT]      = s_reg.at45;
      wv           = merge(ctrl_word, WB_DAT_I, WB_SEL_I);
      req_mode     = wv[readout_pkg::CTRL_MODE_LSB +: 2];
   end

   always_comb begin
      logic accept;
      logic do_line;
      logic want_clear;
      accept     = 1'b0;
      do_line    = 1'b0;
      want_clear = 1'b0;
      s_next     = s_reg;
      s_next.trig_d = EXTERNAL_LINE_TRIGGER;
      s_next.ack    = 1'b0;
      s_next.gclr   = 1'b0;
      s_next.rstart = 1'b0;

      if (s_reg.period != '1) begin
         s_next.period = s_reg.period + CNT_W'(1);
      end

      // bus slave, one wait state
      if (WB_CYC_I && WB_STB_I && !s_reg.ack) begin
         s_next.ack  = 1'b1;
         s_next.rdat = 32'h0;
         unique case (WB_ADR_I)
            readout_pkg::ADR_CTRL: begin
               s_next.rdat = ctrl_word;
               if (WB_WE_I) begin
                  s_next.sens     = wv[readout_pkg::CTRL_SENS_LSB +: 2];
                  s_next.expmode  = wv[readout_pkg::CTRL_EXPM_LSB +: 4];
                  s_next.int_rate = wv[readout_pkg::CTRL_INT_BIT];
                  s_next.at45     = wv[readout_pkg::CTRL_AT45_BIT];
                  if (req_mode <= readout_pkg::MODE_IMM) begin
                     s_next.mode = req_mode;
                  end else begin
                     s_next.istat[readout_pkg::IRQ_BADVAL_BIT] = 1'b1;
                  end
               end
            end
            readout_pkg::ADR_EXPOSURE: begin
               s_next.rdat = s_reg.exposure;
               if (WB_WE_I) begin
                  s_next.exposure = merge(s_reg.exposure, WB_DAT_I, WB_SEL_I);
               end
            end
            readout_pkg::ADR_STATUS: begin
               s_next.rdat = {20'h0, conflict, s_reg.eff_clear, 2'(s_reg.st), WARN_CODE_OUT};
            end
            readout_pkg::ADR_IRQ_STAT: begin
               s_next.rdat = {28'h0, s_reg.istat};
               if (WB_WE_I && WB_SEL_I[0]) begin
                  s_next.istat = s_reg.istat & ~WB_DAT_I[readout_pkg::IRQ_W-1:0];
               end
            end
            readout_pkg::ADR_IRQ_MASK: begin
               s_next.rdat = {28'h0, s_reg.imask};
               if (WB_WE_I && WB_SEL_I[0]) begin
                  s_next.imask = WB_DAT_I[readout_pkg::IRQ_W-1:0];
               end
            end
            readout_pkg::ADR_MODE_Q: begin
               s_next.rdat = {30'h0, s_reg.mode};
            end
            default: begin
               s_next.rdat = 32'h0;
            end
         endcase
      end

      if (SETTINGS_RESTORE) begin
         if (SETTINGS_MODE_IN <= readout_pkg::MODE_IMM) begin
            s_next.mode = SETTINGS_MODE_IN;
         end
      end

      // line trigger handling
      if (line_evt) begin
         if (conflict) begin
            s_next.skip_tog = ~s_reg.skip_tog;
            if (!s_reg.skip_tog) begin
               s_next.istat[readout_pkg::IRQ_SKIP_BIT] = 1'b1;
            end
         end
         if (eff_mode == readout_pkg::MODE_CLEAR) begin
            accept = s_reg.period >= CNT_W'(CLR_PERIOD_CYCLES);
         end else begin
            accept = 1'b1;
         end
         do_line = accept && !(conflict && s_reg.skip_tog) && s_reg.st == readout_pkg::ST_IDLE;
      end

      if (do_line) begin
         s_next.period      = '0;
         s_next.last_period = s_reg.period;
         unique case (eff_mode)
            readout_pkg::MODE_CLEAR: want_clear = 1'b1;
            readout_pkg::MODE_IMM:   want_clear = 1'b0;
            default: begin
               // hysteresis on the line just measured; decided per line so a slow
               // ramp switches cleanly and a jump spoils at most one line
               if (s_reg.eff_clear) begin
                  want_clear = s_reg.period >= CNT_W'(TO_IMM_CYCLES);
               end else begin
                  want_clear = s_reg.period > CNT_W'(TO_CLR_CYCLES);
               end
            end
         endcase
         if (want_clear != s_reg.eff_clear) begin
            s_next.istat[readout_pkg::IRQ_SWITCH_BIT] = 1'b1;
         end
         s_next.eff_clear = want_clear;
         if (want_clear) begin
            s_next.st   = readout_pkg::ST_CLEAR;
            s_next.gclr = 1'b1;
            s_next.cnt  = CNT_W'(EXP_DELAY_CYCLES);
         end else begin
            s_next.rstart = 1'b1;
            s_next.st     = readout_pkg::ST_EXPOSE;
            s_next.cnt    = exp_used[CNT_W-1:0];
            s_next.expo   = 1'b1;
         end
      end else begin
         unique case (s_reg.st)
            readout_pkg::ST_IDLE: begin
               s_next.expo = 1'b0;
            end
            readout_pkg::ST_CLEAR: begin
               s_next.st     = readout_pkg::ST_DELAY;
               s_next.rstart = 1'b1;
            end
            readout_pkg::ST_DELAY: begin
               if (s_reg.cnt <= CNT_W'(1)) begin
                  s_next.st   = readout_pkg::ST_EXPOSE;
                  s_next.cnt  = exp_used[CNT_W-1:0];
                  s_next.expo = 1'b1;
               end else begin
                  s_next.cnt = s_reg.cnt - CNT_W'(1);
               end
            end
            readout_pkg::ST_EXPOSE: begin
               if (s_reg.cnt <= CNT_W'(1)) begin
                  s_next.st   = readout_pkg::ST_IDLE;
                  s_next.expo = 1'b0;
               end else begin
                  s_next.cnt = s_reg.cnt - CNT_W'(1);
               end
            end
         endcase
      end

      if (conflict) begin
         s_next.istat[readout_pkg::IRQ_WARN_BIT] = 1'b1;
      end
   end

   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         s_reg          <= '0;
         s_reg.mode     <= readout_pkg::MODE_RST;
         s_reg.expmode  <= readout_pkg::EXPMODE_RST;
         s_reg.exposure <= readout_pkg::EXPOSURE_RST;
         s_reg.period   <= '1;
         s_reg.st       <= readout_pkg::ST_IDLE;
      end else if (CLK_EN) begin
         s_reg <= s_next;
      end
   end

   always_comb begin
      WB_ACK_O          = s_reg.ack;
      WB_DAT_O          = s_reg.rdat;
      SETTINGS_MODE_OUT = s_reg.mode;
      GATE_CLEAR        = s_reg.gclr;
      READOUT_START     = s_reg.rstart;
      EXPOSE            = s_reg.expo;
      WARN_ACTIVE       = conflict;
      WARN_CODE_OUT     = conflict ? readout_pkg::WARN_CODE : 8'h00;
      IRQ               = |(s_reg.istat & s_reg.imask);
   end
endmodule : readout_mode_ctrl
`default_nettype wire

/* tb/readout_mode_ctrl_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module readout_mode_ctrl_props #(
   parameter int CLR_PERIOD_CYCLES = 100
) (
   input wire logic       SYS_CLK,
   input wire logic       SYS_RST,
   input wire logic       CLK_EN,
   input wire logic       WB_CYC_I,
   input wire logic       WB_STB_I,
   input wire logic       WB_ACK_O,
   input wire logic       SETTINGS_RESTORE,
   input wire logic [1:0] SETTINGS_MODE_IN,
   input wire logic [1:0] SETTINGS_MODE_OUT,
   input wire logic       GATE_CLEAR,
   input wire logic       READOUT_START,
   input wire logic       EXPOSE,
   input wire logic       WARN_ACTIVE,
   input wire logic [7:0] WARN_CODE_OUT
);
   logic [31:0] gap_reg;
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (SYS_RST);
   // cycles since the last gate flush
   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) gap_reg <= 32'hffff_ffff;
      else if (GATE_CLEAR) gap_reg <= 32'h1;
      else if (gap_reg != 32'hffff_ffff) gap_reg <= gap_reg + 32'h1;
   end
   sequence clear_line_s;
      GATE_CLEAR ##1 (READOUT_START && !GATE_CLEAR && !EXPOSE) ##1 !EXPOSE [*8];
   endsequence
   AST_ACK_ONE: assert property (WB_ACK_O && CLK_EN |=> !WB_ACK_O)
      else $error("ack too long");
   AST_ACK_TAKE: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O && CLK_EN |=> WB_ACK_O)
      else $error("no ack");
   AST_CLR_SEQ: assert property (GATE_CLEAR |-> clear_line_s)
      else $error("bad flush sequence");
   AST_IMM_START: assert property (READOUT_START && !$past(GATE_CLEAR) |-> EXPOSE)
      else $error("late exposure");
   AST_CLR_SPACE: assert property (GATE_CLEAR |-> gap_reg >= 32'(CLR_PERIOD_CYCLES))
      else $error("flush rate too high");
   AST_WARN_CODE: assert property (WARN_CODE_OUT == (WARN_ACTIVE ? 8'h09 : 8'h00))
      else $error("bad warning code");
   AST_RESTORE: assert property (SETTINGS_RESTORE && CLK_EN && SETTINGS_MODE_IN != 2'h3
      |=> SETTINGS_MODE_OUT == $past(SETTINGS_MODE_IN)) else $error("restore lost");
   AST_RST_DEF: assert property ($fell(SYS_RST) |-> SETTINGS_MODE_OUT == readout_pkg::MODE_RST)
      else $error("bad reset mode");
endmodule : readout_mode_ctrl_props
bind readout_mode_ctrl readout_mode_ctrl_props #(.CLR_PERIOD_CYCLES(CLR_PERIOD_CYCLES)) i_props (
   .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
   .WB_ACK_O(WB_ACK_O), .SETTINGS_RESTORE(SETTINGS_RESTORE), .SETTINGS_MODE_IN(SETTINGS_MODE_IN),
   .SETTINGS_MODE_OUT(SETTINGS_MODE_OUT), .GATE_CLEAR(GATE_CLEAR), .READOUT_START(READOUT_START),
   .EXPOSE(EXPOSE), .WARN_ACTIVE(WARN_ACTIVE), .WARN_CODE_OUT(WARN_CODE_OUT));
`default_nettype wire

/* tb/line_source.sv */
`timescale 1ns/10ps
`default_nettype none
module line_source (
   input  wire logic clk,
   output var logic  trig,
   output var logic  pulse
);
   initial begin
      trig = 1'b1;
      pulse = 1'b0;
   end
   // trigger idles high; a line event is its falling edge
   task automatic fire(input logic internal, input int lo);
      if (internal) begin
         pulse <= 1'b1;
         @(posedge clk);
         pulse <= 1'b0;
      end else begin
         trig <= 1'b0;
         repeat (lo) @(posedge clk);
         trig <= 1'b1;
      end
   endtask : fire
endmodule : line_source
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
   localparam int EXP_DLY = 12;
   typedef struct {logic [15:0] ctrl; logic [31:0] expo; int gap, w, n, gc, rs, ex;} row_t;
   logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, rsto = 1'b0, en = 1'b1;
   logic [4:0]  adr = 5'h00;
   logic [1:0]  m_in = 2'h0;
   logic [31:0] dat = 32'h0, rdat, q;
   logic [1:0]  m_out;
   logic [7:0]  wcode;
   logic        ack, trig, pulse, gc, rs, ex, warn, irq;
   int          err_count = 0, checks_done = 0, n_gc = 0, n_rs = 0, n_ex = 0;
   row_t rows [8] = '{
      '{16'h0702, 32'ha, 120, 1, 3, 0, 3, 30},
      '{16'h0701, 32'ha, 120, 1, 3, 3, 3, 30},
      '{16'h0701, 32'ha, 50, 1, 1, 0, 0, 0},
      '{16'h0700, 32'ha, 200, 2, 3, 3, 3, 30},
      '{16'h0700, 32'h19, 55, 2, 3, 0, 3, 3 * EXP_DLY},
      '{16'h0711, 32'ha, 120, 1, 3, 0, 3, 30},
      '{16'h3702, 32'ha, 120, 1, 4, 0, 4, 40},
      '{16'h3701, 32'ha, 120, 1, 4, 2, 2, 20}};
   readout_mode_ctrl #(.EXP_DELAY_CYCLES(EXP_DLY), .CLR_PERIOD_CYCLES(100), .TO_IMM_CYCLES(60),
      .TO_CLR_CYCLES(80)) i_dut (
      .SYS_CLK(clk), .SYS_RST(rst), .CLK_EN(en), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
      .EXTERNAL_LINE_TRIGGER(trig), .INTERNAL_LINE_PULSE(pulse), .SETTINGS_RESTORE(rsto),
      .SETTINGS_MODE_IN(m_in), .SETTINGS_MODE_OUT(m_out), .GATE_CLEAR(gc), .READOUT_START(rs),
      .EXPOSE(ex), .WARN_ACTIVE(warn), .WARN_CODE_OUT(wcode), .IRQ(irq));
   line_source i_src (.clk(clk), .trig(trig), .pulse(pulse));
   initial begin
      forever #2 clk = ~clk;
   end
   always @(negedge clk) begin
      n_gc += int'(gc);
      n_rs += int'(rs);
      n_ex += int'(ex);
   end
   task automatic results();
      if (err_count == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      // only the watchdog ends a wait for ack
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask : wb
   task automatic shot(input logic internal, input int gap);
      i_src.fire(internal, 2);
      repeat (gap - (internal ? 1 : 2)) @(posedge clk);
   endtask : shot
   task automatic line(input row_t r);
      int g, s, e;
      wb(1'b1, 5'h04, r.expo);
      wb(1'b1, 5'h00, {16'h0, r.ctrl});
      repeat (r.w) shot(r.ctrl[12], r.gap);
      g = n_gc;
      s = n_rs;
      e = n_ex;
      repeat (r.n) shot(r.ctrl[12], r.gap);
      chk(32'(n_gc - g), 32'(r.gc));
      chk(32'(n_rs - s), 32'(r.rs));
      chk(32'(n_ex - e), 32'(r.ex));
   endtask : line
   initial begin
      repeat (60000) @(posedge clk);
      err_count++;
      results();
   end
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      foreach (rows[i]) line(rows[i]);
      chk(32'(warn), 32'h1);
      chk(32'(wcode), 32'h9);
      wb(1'b0, 5'h08, 32'h0);
      chk(q & 32'hff, 32'h9);
      wb(1'b0, 5'h0c, 32'h0);
      chk(q & 32'h5, 32'h5);
      wb(1'b1, 5'h00, 32'h0702);
      wb(1'b1, 5'h10, 32'h3);
      chk(32'(irq), 32'h1);
      wb(1'b1, 5'h0c, 32'hf);
      chk(32'(irq), 32'h0);
      wb(1'b1, 5'h00, 32'h0703);
      chk(32'(irq), 32'h1);
      wb(1'b0, 5'h14, 32'h0);
      chk(q, 32'h2);
      rsto <= 1'b1;
      m_in <= 2'h1;
      @(posedge clk);
      rsto <= 1'b0;
      @(posedge clk);
      chk(32'(m_out), 32'h1);
      rsto <= 1'b1;
      m_in <= 2'h3;
      @(posedge clk);
      rsto <= 1'b0;
      @(posedge clk);
      wb(1'b0, 5'h14, 32'h0);
      chk(q, 32'h1);
      // clock enable low: a restore pulse must not land
      en <= 1'b0;
      rsto <= 1'b1;
      m_in <= 2'h0;
      @(posedge clk);
      rsto <= 1'b0;
      en <= 1'b1;
      @(posedge clk);
      chk(32'(m_out), 32'h1);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk(32'(m_out), 32'h2);
      wb(1'b0, 5'h00, 32'h0);
      chk(q, 32'h0702);
      wb(1'b0, 5'h04, 32'h0);
      chk(q, 32'hfa0);
      wb(1'b0, 5'h1c, 32'h0);
      chk(q, 32'h0);
      results();
   end
endmodule : testbench
`default_nettype wire
